// *** logic/area_decode.sv ***
// Notes on behaviour
// - Address bits 28:26 = 011 select area 3.
// - Code 100 selects area 4, normal memory only.
// - Code 101 selects area 5, shadowed.
// - Code 110 selects area 6, shadowed.
// - Area 3 normal width from its width field.
// - Area 3 DRAM types: word/longword from width bit.
// - Area 3 select asserts for every type.
// - Area 3 normal: read, byte writes, 0-3 waits.
// - External wait honoured for normal, burst ROM and card; not DRAM types.
// - Area 3 SDRAM: row, column, R/W, masks.
// - Pseudo-SRAM: enable, output-enable/refresh, byte writes.
// - Area 3 timing and muxing from memory control.
// - Area 2 SDRAM timing from memory control.
// - Area 2 DRAM: second strobes, B-control timing.
// - Area 4 width field, waits 0-10.
// - Area 5 card maps lower 32 Mbytes only.
// - Areas 5/6 normal/burst: byte, word, longword.
// - Areas 5/6 card: byte or word only.
// - Area 5 select, or card A strobes.
// - Area 5 waits 0-10 plus external wait.
// - Burst beats spaced 2 to 10 cycles.
// - Card setup and hold extension per fields.
// - Area 6 card: memory low, I/O high.
// - Area 6 select, or card B strobes.
// - External wait sampled only leaving last wait.
// - No-wait normal access takes two cycles.
`timescale 1ns/1ns
`default_nettype none
`include "area_decode_regs.svh"

module area_decode (
  // Clock and reset.
  input  wire logic                     REF_CLK,
  input  wire logic                     RESET,
  // Access request from the core.
  input  wire logic                     REQ_VALID,
  input  wire logic [31:0]              REQ_ADDR,
  input  wire logic                     REQ_WRITE,
  input  wire area_decode_pkg::size_t   REQ_SIZE,
  input  wire logic                     REQ_BURST,
  output logic                          REQ_READY,
  output logic                          REQ_ACK,
  output logic                          REQ_UNMAPPED,
  // Configuration fields.
  input  wire area_decode_pkg::cfg_t    CFG,
  // External wait pin, active low, asynchronous.
  input  wire logic                     WAIT_N,
  // Memory side.
  output area_decode_pkg::strobe_t      STROBES,
  output logic [25:0]                   ADDR_OUT,
  output area_decode_pkg::width_t       BUS_WIDTH
);

  area_decode_pkg::core_t q;
  area_decode_pkg::core_t d;

  // Three-bit wait code to cycles, 0 to 10.
  function automatic logic [3:0] wait_cycles(input logic [2:0] code);
    logic [31:0] table_v;
    table_v = `WAIT_TABLE;
    wait_cycles = table_v[code*4 +: 4];
  endfunction

  // Byte lanes touched by an access, little endian.
  function automatic logic [3:0] lanes_of(input area_decode_pkg::size_t sz, input logic [1:0] a);
    lanes_of = 4'hF;
    if (sz == area_decode_pkg::SZ_BYTE) begin
      lanes_of = 4'h1 << a;
    end else if (sz == area_decode_pkg::SZ_WORD) begin
      lanes_of = a[1] ? 4'hC : 4'h3;
    end
  endfunction

  // Card interfaces cannot run longword, so clamp such a field to word.
  function automatic area_decode_pkg::width_t card_width(input area_decode_pkg::width_t w);
    card_width = (w == area_decode_pkg::W_BYTE) ? area_decode_pkg::W_BYTE : area_decode_pkg::W_WORD;
  endfunction

  // Burst pitch follows the wait count, held inside its limits.
  function automatic logic [3:0] pitch_of(input logic [3:0] w);
    logic [4:0] p;
    p = {1'b0, w} + {1'b0, `PITCH_MIN};
    pitch_of = (p > {1'b0, `PITCH_MAX}) ? `PITCH_MAX : p[3:0];
  endfunction

  // Row address on pins A15..A1, shifted by the column width.
  function automatic logic [25:0] row_mux(input logic [31:0] a, input logic [1:0] amx);
    logic [31:0] r;
    r = a >> (`ROW_SHIFT_BASE + {3'h0, amx});
    row_mux = {a[25:16], r[15:1], 1'b0};
  endfunction

  // Negated strobe set shown between accesses.
  function automatic area_decode_pkg::strobe_t idle_strobes();
    idle_strobes = '1;
  endfunction

  // Next-state logic: decode, sequencing and strobe generation.
  always_comb begin
    d = q;
    d.wait_meta = ~WAIT_N;
    d.wait_sync = q.wait_meta;
    d.unmapped = 1'b0;
    unique case (q.state)
      area_decode_pkg::S_IDLE: begin
        if (REQ_VALID) begin
          d.addr = REQ_ADDR;
          d.write = REQ_WRITE;
          d.lanes = lanes_of(REQ_SIZE, REQ_ADDR[1:0]);
          d.area = REQ_ADDR[`AREA_FIELD_HI:`AREA_FIELD_LO];
          d.kind = area_decode_pkg::K_NORMAL;
          d.waits = 4'h0;
          d.hold = 2'h0;
          d.beats = 2'h0;
          d.io = REQ_ADDR[`CARD_IO_BIT];
          d.rcd = CFG.mem_rcd;
          d.amx = CFG.mem_amx;
          d.width = area_decode_pkg::W_LONG;
          d.cnt = 4'h0;
          d.state = area_decode_pkg::S_T1;
          unique case (d.area)
            `AREA_CODE_2: begin
              if (CFG.area2_type == 2'h1) begin
                d.kind = area_decode_pkg::K_DRAM;
                d.rcd = CFG.dram_b_rcd;
                d.amx = CFG.dram_b_amx;
                d.width = area_decode_pkg::W_WORD;
              end else if (CFG.area2_type == 2'h2) begin
                d.kind = area_decode_pkg::K_SDRAM;
                d.width = CFG.dram_width_bit ? area_decode_pkg::W_LONG : area_decode_pkg::W_WORD;
              end
            end
            `AREA_CODE_3: begin
              d.kind = (CFG.area3_type == 2'h1) ? area_decode_pkg::K_DRAM :
                       (CFG.area3_type == 2'h2) ? area_decode_pkg::K_PSRAM :
                       (CFG.area3_type == 2'h3) ? area_decode_pkg::K_SDRAM : area_decode_pkg::K_NORMAL;
              d.waits = {2'h0, CFG.area3_wait_field};
              if (d.kind == area_decode_pkg::K_NORMAL) begin
                d.width = CFG.area3_width_field;
              end else begin
                d.width = CFG.dram_width_bit ? area_decode_pkg::W_LONG : area_decode_pkg::W_WORD;
              end
            end
            `AREA_CODE_4: begin
              d.width = CFG.area4_width_field;
              d.waits = wait_cycles(CFG.area4_wait_field);
            end
            `AREA_CODE_5, `AREA_CODE_6: begin
              d.kind = (((d.area == `AREA_CODE_5) ? CFG.area5_type : CFG.area6_type) == 2'h2) ?
                       area_decode_pkg::K_CARD :
                       (((d.area == `AREA_CODE_5) ? CFG.area5_type : CFG.area6_type) == 2'h1) ?
                       area_decode_pkg::K_BURST : area_decode_pkg::K_NORMAL;
              d.width = (d.area == `AREA_CODE_5) ? CFG.area5_width_field : CFG.area6_width_field;
              d.waits = wait_cycles((d.area == `AREA_CODE_5) ? CFG.area5_wait_field
                                                             : CFG.area6_wait_field);
              if (d.kind == area_decode_pkg::K_CARD) begin
                d.width = card_width(d.width);
                d.cnt = 4'h1 + {2'h0, (d.area == `AREA_CODE_5) ? CFG.area5_setup_ext
                                                               : CFG.area6_setup_ext};
                d.hold = (d.area == `AREA_CODE_5) ? CFG.area5_hold_ext : CFG.area6_hold_ext;
                d.state = area_decode_pkg::S_SETUP;
                if (d.area == `AREA_CODE_5 && d.io) begin
                  d.state = area_decode_pkg::S_IDLE;
                  d.unmapped = 1'b1;
                end
              end
              if (d.kind == area_decode_pkg::K_BURST && REQ_BURST) begin
                d.beats = `BURST_EXTRA;
              end
            end
            default: begin
              d.state = area_decode_pkg::S_IDLE;
              d.unmapped = 1'b1;
            end
          endcase
          d.honour_wait = (d.kind == area_decode_pkg::K_NORMAL) || (d.kind == area_decode_pkg::K_BURST) ||
                          (d.kind == area_decode_pkg::K_CARD);
          if (d.kind == area_decode_pkg::K_DRAM || d.kind == area_decode_pkg::K_PSRAM ||
              d.kind == area_decode_pkg::K_SDRAM) begin
            d.state = area_decode_pkg::S_ROW;
          end
        end
      end
      area_decode_pkg::S_SETUP: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.state = area_decode_pkg::S_T1;
        end
      end
      area_decode_pkg::S_T1: begin
        d.cnt = q.waits;
        d.state = (q.waits != 4'h0) ? area_decode_pkg::S_TW : area_decode_pkg::S_T2;
      end
      area_decode_pkg::S_TW: begin
        if (q.cnt != 4'h1) begin
          d.cnt = q.cnt - 4'h1;
        end else if (!(q.honour_wait && q.wait_sync)) begin
          d.state = area_decode_pkg::S_T2;
        end
      end
      area_decode_pkg::S_T2: begin
        if (q.beats != 2'h0) begin
          d.beats = q.beats - 2'h1;
          d.cnt = pitch_of(q.waits) - 4'h1;
          d.state = area_decode_pkg::S_PITCH;
        end else if (q.kind == area_decode_pkg::K_CARD) begin
          d.cnt = 4'h1 + {2'h0, q.hold};
          d.state = area_decode_pkg::S_HOLD;
        end else begin
          d.state = area_decode_pkg::S_IDLE;
        end
      end
      area_decode_pkg::S_PITCH: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.state = area_decode_pkg::S_T2;
        end
      end
      area_decode_pkg::S_HOLD: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.state = area_decode_pkg::S_IDLE;
        end
      end
      area_decode_pkg::S_ROW: begin
        d.cnt = (q.rcd != 2'h0) ? {2'h0, q.rcd} : 4'h1 + ((q.waits > `COL_MAX - 4'h1) ? `COL_MAX - 4'h1 : q.waits);
        d.state = (q.rcd != 2'h0) ? area_decode_pkg::S_RCD : area_decode_pkg::S_COL;
      end
      area_decode_pkg::S_RCD: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.cnt = 4'h1 + ((q.waits > `COL_MAX - 4'h1) ? `COL_MAX - 4'h1 : q.waits);
          d.state = area_decode_pkg::S_COL;
        end
      end
      area_decode_pkg::S_COL: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.state = area_decode_pkg::S_IDLE;
        end
      end
      default: begin
        d.state = area_decode_pkg::S_IDLE;
      end
    endcase

    // Strobes follow the next state so that they leave flip-flops.
    d.st = idle_strobes();
    d.addr_out = d.addr[25:0];
    if (d.state != area_decode_pkg::S_IDLE) begin
      unique case (d.kind)
        area_decode_pkg::K_NORMAL, area_decode_pkg::K_BURST, area_decode_pkg::K_CARD: begin
          if (d.state == area_decode_pkg::S_T1 || d.state == area_decode_pkg::S_TW ||
              d.state == area_decode_pkg::S_T2 || d.state == area_decode_pkg::S_PITCH) begin
            if (d.kind != area_decode_pkg::K_CARD) begin
              d.st.read_n = d.write;
              d.st.byte_write_strobes_n = ~(d.lanes & {4{d.write}});
            end else if (d.area == `AREA_CODE_6 && d.io) begin
              d.st.card_io_read_n = d.write;
              d.st.card_io_write_n = ~d.write;
            end else begin
              d.st.read_n = d.write;
              d.st.byte_write_strobes_n[1] = ~d.write;
            end
          end
        end
        area_decode_pkg::K_DRAM: begin
          if (d.area == `AREA_CODE_2) begin
            d.st.row_strobe_second_n = 1'b0;
            d.st.col_strobe_b_high_n = ~((d.state == area_decode_pkg::S_COL) & d.lanes[1]);
            d.st.col_strobe_b_low_n = ~((d.state == area_decode_pkg::S_COL) & d.lanes[0]);
          end else begin
            d.st.row_strobe_n = 1'b0;
            d.st.col_strobe_top_byte_n = ~((d.state == area_decode_pkg::S_COL) & d.lanes[3]);
            d.st.col_strobe_third_byte_n = ~((d.state == area_decode_pkg::S_COL) & d.lanes[2]);
          end
          d.st.read_write_n = ~d.write;
        end
        area_decode_pkg::K_SDRAM: begin
          d.st.row_strobe_n = ~(d.state == area_decode_pkg::S_ROW);
          d.st.col_strobe_n = ~(d.state == area_decode_pkg::S_COL);
          d.st.read_write_n = ~d.write;
          {d.st.byte_mask_3, d.st.byte_mask_2, d.st.byte_mask_1, d.st.byte_mask_0} = ~d.lanes;
        end
        area_decode_pkg::K_PSRAM: begin
          d.st.out_enable_refresh_n = ~((d.state == area_decode_pkg::S_COL) & ~d.write);
          d.st.byte_write_strobes_n = ~(d.lanes & {4{(d.state == area_decode_pkg::S_COL) & d.write}});
        end
        default: begin
          d.st = idle_strobes();
        end
      endcase
      if (d.state == area_decode_pkg::S_ROW || d.state == area_decode_pkg::S_RCD) begin
        d.addr_out = row_mux(d.addr, d.amx);
      end
      // One area select per access; card areas drive card enables instead.
      d.st.area2_select_n = ~(d.area == `AREA_CODE_2);
      d.st.area3_select_n = ~(d.area == `AREA_CODE_3);
      d.st.area4_select_n = ~(d.area == `AREA_CODE_4);
      d.st.area5_select_n = ~(d.area == `AREA_CODE_5 && d.kind != area_decode_pkg::K_CARD);
      d.st.area6_select_n = ~(d.area == `AREA_CODE_6 && d.kind != area_decode_pkg::K_CARD);
      if (d.kind == area_decode_pkg::K_CARD && d.area == `AREA_CODE_5) begin
        d.st.card_a_enable_low_n = ~(d.lanes[0] | d.lanes[2]);
        d.st.card_a_enable_high_n = ~(d.lanes[1] | d.lanes[3]);
      end
      if (d.kind == area_decode_pkg::K_CARD && d.area == `AREA_CODE_6) begin
        d.st.card_b_enable_low_n = ~(d.lanes[0] | d.lanes[2]);
        d.st.card_b_enable_high_n = ~(d.lanes[1] | d.lanes[3]);
      end
    end
  end

  // All state registers here, with a synchronous reset.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      q <= '0;
      q.st <= '1;
      q.width <= area_decode_pkg::W_LONG;
    end else begin
      q <= d;
    end
  end

  // Handshake outputs are decoded from the state; data outputs are registered.
  assign REQ_READY = (q.state == area_decode_pkg::S_IDLE);
  assign REQ_ACK = (q.state == area_decode_pkg::S_T2 && q.kind != area_decode_pkg::K_CARD) ||
                   (q.state == area_decode_pkg::S_HOLD && q.cnt == 4'h1) ||
                   (q.state == area_decode_pkg::S_COL && q.cnt == 4'h1);
  assign REQ_UNMAPPED = q.unmapped;
  assign STROBES = q.st;
  assign ADDR_OUT = q.addr_out;
  assign BUS_WIDTH = q.width;

  // Checks on the decode and the cycle sequence.
  logic [4:0] sel_count;
  assign sel_count = 5'(!q.st.area2_select_n) + 5'(!q.st.area3_select_n) + 5'(!q.st.area4_select_n) +
                     5'(!q.st.area5_select_n) + 5'(!q.st.area6_select_n);

  chk_one_select: assert property (@(posedge REF_CLK) disable iff (RESET)
    sel_count <= 5'h1) else $error("More than one area select active.");
  chk_area3_decode: assert property (@(posedge REF_CLK) disable iff (RESET)
    REQ_READY && REQ_VALID && REQ_ADDR[28:26] == 3'h3 |=> !STROBES.area3_select_n)
    else $error("Area 3 access without area 3 select.");
  chk_area4_decode: assert property (@(posedge REF_CLK) disable iff (RESET)
    REQ_READY && REQ_VALID && REQ_ADDR[28:26] == 3'h4 |=>
    !STROBES.area4_select_n && BUS_WIDTH == $past(CFG.area4_width_field))
    else $error("Area 4 access decoded wrongly.");
  chk_nowait_two: assert property (@(posedge REF_CLK) disable iff (RESET)
    REQ_READY && REQ_VALID && REQ_ADDR[28:26] == 3'h4 && CFG.area4_wait_field == 3'h0 |=> ##1 REQ_ACK)
    else $error("No-wait access did not end in two cycles.");
  chk_wait_stretch: assert property (@(posedge REF_CLK) disable iff (RESET)
    q.state == area_decode_pkg::S_TW && q.cnt == 4'h1 && q.honour_wait && q.wait_sync |=> q.state == area_decode_pkg::S_TW)
    else $error("External wait not honoured at the last wait cycle.");
  chk_dram_no_wait: assert property (@(posedge REF_CLK) disable iff (RESET)
    q.kind == area_decode_pkg::K_DRAM || q.kind == area_decode_pkg::K_SDRAM |-> !q.honour_wait || REQ_READY)
    else $error("External wait enabled for a DRAM type.");
  chk_card_width: assert property (@(posedge REF_CLK) disable iff (RESET)
    q.kind == area_decode_pkg::K_CARD && !REQ_READY |-> BUS_WIDTH != area_decode_pkg::W_LONG)
    else $error("Card interface running longword.");
  chk_card5_low: assert property (@(posedge REF_CLK) disable iff (RESET)
    !STROBES.card_a_enable_low_n || !STROBES.card_a_enable_high_n |-> !q.addr[25])
    else $error("Area 5 card enable in the upper half.");
  chk_burst_pitch: assert property (@(posedge REF_CLK) disable iff (RESET)
    q.state == area_decode_pkg::S_T2 && q.beats != 2'h0 |-> ##[2:10] q.state == area_decode_pkg::S_T2)
    else $error("Burst pitch outside 2 to 10 cycles.");
  chk_sdram_masks: assert property (@(posedge REF_CLK) disable iff (RESET)
    q.kind == area_decode_pkg::K_SDRAM && q.state == area_decode_pkg::S_COL |->
    !STROBES.col_strobe_n && STROBES.byte_mask_0 == !q.lanes[0]) else $error("SDRAM column strobes wrong.");
  cov_wait_ext: cover property (@(posedge REF_CLK) q.state == area_decode_pkg::S_TW && q.wait_sync);
  cov_card_hold: cover property (@(posedge REF_CLK) q.state == area_decode_pkg::S_HOLD);
  cov_dram_col: cover property (@(posedge REF_CLK) q.state == area_decode_pkg::S_COL && q.kind == area_decode_pkg::K_DRAM);
  cov_burst_pitch: cover property (@(posedge REF_CLK) q.state == area_decode_pkg::S_PITCH);

endmodule

`default_nettype wire

// *** logic/area_decode_regs.svh ***
`ifndef AREA_DECODE_REGS_SVH
`define AREA_DECODE_REGS_SVH

// Address field that picks the area; bits above it are shadow copies.
`define AREA_FIELD_HI    28
`define AREA_FIELD_LO    26
`define AREA_CODE_2      3'h2
`define AREA_CODE_3      3'h3
`define AREA_CODE_4      3'h4
`define AREA_CODE_5      3'h5
`define AREA_CODE_6      3'h6
// Splits a card area into memory space (low half) and I/O space (high half); area 5 maps the low half only.
`define CARD_IO_BIT      25

// Software wait table for three-bit wait fields, index 7 first.
`define WAIT_TABLE       {4'hA, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0}
// Burst pitch limits in cycles and number of extra beats in one burst.
`define PITCH_MIN        4'h2
`define PITCH_MAX        4'hA
`define BURST_EXTRA      2'h3
// Longest column phase in cycles, and base shift of the row address.
`define COL_MAX          4'h3
`define ROW_SHIFT_BASE   5'h08

`endif

// *** logic/area_decode_pkg.sv ***
`default_nettype none
package area_decode_pkg;

  typedef enum logic [2:0] {
    K_NORMAL = 3'h0, K_BURST = 3'h1, K_CARD = 3'h2,
    K_DRAM   = 3'h3, K_PSRAM = 3'h4, K_SDRAM = 3'h5
  } kind_t;

  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} size_t;

  // Field encoding of every width field: 01 byte, 10 word, 11 and 00 longword.
  typedef enum logic [1:0] {W_LONG0 = 2'h0, W_BYTE = 2'h1, W_WORD = 2'h2, W_LONG = 2'h3} width_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_SETUP = 4'h1, S_T1 = 4'h2, S_TW = 4'h3, S_T2 = 4'h4,
    S_PITCH = 4'h5, S_HOLD = 4'h6, S_ROW = 4'h7, S_RCD = 4'h8, S_COL = 4'h9
  } state_t;

  // Memory type per area: area2 uses 0 normal 1 DRAM 2 SDRAM,
  // area3 0 normal 1 DRAM 2 pseudo-SRAM 3 SDRAM, areas 5 and 6 0 normal 1 burst ROM 2 card.
  typedef struct packed {
    logic [1:0] area2_type;
    logic [1:0] area3_type;
    logic [1:0] area5_type;
    logic [1:0] area6_type;
    width_t     area3_width_field;
    width_t     area4_width_field;
    width_t     area5_width_field;
    width_t     area6_width_field;
    logic       dram_width_bit;
    logic [1:0] area3_wait_field;
    logic [2:0] area4_wait_field;
    logic [2:0] area5_wait_field;
    logic [2:0] area6_wait_field;
    logic [1:0] area5_setup_ext;
    logic [1:0] area5_hold_ext;
    logic [1:0] area6_setup_ext;
    logic [1:0] area6_hold_ext;
    logic [1:0] mem_rcd;
    logic [1:0] mem_amx;
    logic [1:0] dram_b_rcd;
    logic [1:0] dram_b_amx;
  } cfg_t;

  typedef struct packed {
    logic       area2_select_n;
    logic       area3_select_n;
    logic       area4_select_n;
    logic       area5_select_n;
    logic       area6_select_n;
    logic       read_n;
    logic [3:0] byte_write_strobes_n;
    logic       row_strobe_n;
    logic       col_strobe_n;
    logic       read_write_n;
    logic       col_strobe_top_byte_n;
    logic       col_strobe_third_byte_n;
    logic       row_strobe_second_n;
    logic       col_strobe_b_high_n;
    logic       col_strobe_b_low_n;
    logic       byte_mask_3;
    logic       byte_mask_2;
    logic       byte_mask_1;
    logic       byte_mask_0;
    logic       out_enable_refresh_n;
    logic       card_a_enable_low_n;
    logic       card_a_enable_high_n;
    logic       card_b_enable_low_n;
    logic       card_b_enable_high_n;
    logic       card_io_read_n;
    logic       card_io_write_n;
  } strobe_t;

  typedef struct packed {
    state_t      state;
    logic [3:0]  cnt;
    logic [3:0]  waits;
    logic [1:0]  hold;
    logic [1:0]  beats;
    logic [2:0]  area;
    kind_t       kind;
    logic        write;
    logic [3:0]  lanes;
    logic [31:0] addr;
    logic        honour_wait;
    logic        io;
    logic [1:0]  rcd;
    logic [1:0]  amx;
    width_t      width;
    logic [25:0] addr_out;
    strobe_t     st;
    logic        wait_meta;
    logic        wait_sync;
    logic        unmapped;
  } core_t;

endpackage
`default_nettype wire

// *** verification/mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  // Clock and stall request from the bench.
  input  wire logic                     REF_CLK,
  input  wire logic                     stall,
  // Strobes seen from the memory side.
  input  wire area_decode_pkg::strobe_t st,
  output logic                          WAIT_N
);
  logic       sel;
  logic [3:0] busy;

  // Any area select means this memory is addressed.
  assign sel = !(&{st.area2_select_n, st.area3_select_n, st.area4_select_n, st.area5_select_n, st.area6_select_n});

  // Counts the cycles of the current selection, saturating at its top.
  always_ff @(posedge REF_CLK) begin
    busy <= sel ? busy + {3'h0, busy != 4'hF} : 4'h0;
  end

  // A slow memory pulls wait low for its first six selected cycles; the pull-up holds it high otherwise.
  assign WAIT_N = !(stall && sel && busy < 4'h6);
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                     ref_clk = 1'b0, reset = 1'b1, valid = 1'b0, write = 1'b0, stall = 1'b0, burst = 1'b0;
  logic [31:0]              addr = 32'h0;
  area_decode_pkg::cfg_t    cfg = '0;
  area_decode_pkg::strobe_t st;
  area_decode_pkg::width_t  bw;
  logic                     ready, ack, unm, wait_n;
  logic [25:0]              aout;
  int                       n_fail = 0, checks = 0, n, n0;

  // Free-running 125 MHz clock.
  initial forever #4 ref_clk = ~ref_clk;

  area_decode dut (.REF_CLK(ref_clk), .RESET(reset), .REQ_VALID(valid), .REQ_ADDR(addr),
    .REQ_WRITE(write), .REQ_SIZE(area_decode_pkg::SZ_LONG), .REQ_BURST(burst), .REQ_READY(ready),
    .REQ_ACK(ack), .REQ_UNMAPPED(unm), .CFG(cfg), .WAIT_N(wait_n), .STROBES(st), .ADDR_OUT(aout),
    .BUS_WIDTH(bw));
  mem_model mem (.REF_CLK(ref_clk), .stall(stall), .st(st), .WAIT_N(wait_n));

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One access held until the design is ready; counts cycles to the ack, then checks the outputs.
  task automatic acc(input logic [31:0] a, input logic [4:0] sel, input int en, input logic [1:0] ew,
                     input logic [4:0] es);
    addr = a;
    valid = 1'b1;
    while (ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    valid = 1'b0;
    n = 1;
    while (ack !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk(32'(ack), 32'h1);
    chk(32'({st.area2_select_n, st.area3_select_n, st.area4_select_n, st.area5_select_n,
      st.area6_select_n}), 32'(sel));
    chk(32'(bw), 32'(ew));
    chk(32'({st.read_n, st.byte_write_strobes_n}), 32'(es));
    chk(32'(aout), 32'(a[25:0]));
    if (en != 0) chk(32'(n), 32'(en));
    $display("access %h done in %0d cycles", a, n);
    @(negedge ref_clk);
  endtask

  // A request to an unmapped window starts no cycle and flags for one cycle.
  task automatic miss(input logic [31:0] a);
    addr = a;
    valid = 1'b1;
    @(negedge ref_clk);
    valid = 1'b0;
    chk(32'(unm), 32'h1);
    chk(32'(ready), 32'h1);
    @(negedge ref_clk);
    chk(32'(unm), 32'h0);
    $display("unmapped %h flagged", a);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  // Test sequence, all inputs changed on falling edges.
  initial begin
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    cfg.area4_width_field = area_decode_pkg::W_BYTE;
    acc(32'h1000_1234, 5'h1B, 2, 2'h1, 5'h0F);
    cfg.area4_wait_field = 3'h7;
    write = 1'b1;
    acc(32'hF000_0000, 5'h1B, 12, 2'h1, 5'h10);
    cfg.area3_wait_field = 2'h3;
    cfg.area3_width_field = area_decode_pkg::W_WORD;
    acc(32'hEC00_0000, 5'h17, 5, 2'h2, 5'h10);
    cfg.area5_wait_field = 3'h5;
    acc(32'h3400_0000, 5'h1D, 8, 2'h0, 5'h10);
    cfg.area6_wait_field = 3'h4;
    write = 1'b0;
    acc(32'h5800_0000, 5'h1E, 6, 2'h0, 5'h0F);
    // Burst ROM in area 6: three more beats follow the first acknowledge.
    cfg.area6_type = 2'h1;
    burst = 1'b1;
    acc(32'h5800_0000, 5'h1E, 6, 2'h0, 5'h0F);
    burst = 1'b0;
    n0 = 0;
    while (ready !== 1'b1) begin
      @(negedge ref_clk);
      n0 = n0 + int'(ack);
    end
    chk(32'(n0), 32'h3);
    // The card sits in area 5, where a coinciding refresh does no harm.
    cfg.area5_type = 2'h2;
    cfg.area5_setup_ext = 2'h3;
    cfg.area5_hold_ext = 2'h1;
    cfg.area5_wait_field = 3'h0;
    cfg.area5_width_field = area_decode_pkg::W_LONG;
    acc(32'h1400_0000, 5'h1F, 8, 2'h2, 5'h1F);
    miss(32'h1600_0000);
    miss(32'h1C00_0000);
    cfg.area4_wait_field = 3'h2;
    stall = 1'b1;
    acc(32'h1000_0000, 5'h1B, 10, 2'h1, 5'h0F);
    chk(32'(n > 4), 32'h1);
    cfg.dram_width_bit = 1'b1;
    cfg.area2_type = 2'h1;
    cfg.dram_b_rcd = 2'h1;
    acc(32'h0800_0000, 5'h0F, 3, 2'h2, 5'h1F);
    for (int t = 1; t < 4; t++) begin
      cfg.area3_type = t[1:0];
      stall = 1'b0;
      acc(32'h0C00_5678, 5'h17, 4, 2'h3, 5'h1F);
      n0 = n;
      stall = 1'b1;
      acc(32'h0C00_5678, 5'h17, 4, 2'h3, 5'h1F);
      chk(32'(n), 32'(n0));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
